// >>> rtl/fcag_pkg.sv
// Package: register map, field positions and timing constants of the sound generator
package fcag_pkg;
	// ====================================================================
	// Register map (printed offsets are not multiples of four: byte address = 4 x index)
	localparam logic [15:0] REG_CH1_FREQ_IDX   = 16'hD200;
	localparam logic [15:0] REG_CH1_CTRL_IDX   = 16'hD201;
	localparam logic [15:0] REG_CH2_FREQ_IDX   = 16'hD202;
	localparam logic [15:0] REG_CH2_CTRL_IDX   = 16'hD203;
	localparam logic [15:0] REG_CH3_FREQ_IDX   = 16'hD204;
	localparam logic [15:0] REG_CH3_CTRL_IDX   = 16'hD205;
	localparam logic [15:0] REG_CH4_FREQ_IDX   = 16'hD206;
	localparam logic [15:0] REG_CH4_CTRL_IDX   = 16'hD207;
	localparam logic [15:0] REG_GLOBAL_IDX     = 16'hD208;
	localparam logic [15:0] REG_STATUS_IDX     = 16'hD209;
	localparam int          ADDR_W             = 18;
	// ====================================================================
	// Control byte fields
	localparam int CTRL_VOL_MSB      = 3;
	localparam int CTRL_VOL_ONLY     = 4;
	localparam int CTRL_PURE_TONE    = 5;
	localparam int CTRL_NOISE_SELECT = 6;
	localparam int CTRL_CLOCK_DIRECT = 7;
	// ====================================================================
	// Global control fields
	localparam int GLB_SLOW_BASE_SEL = 0;
	localparam int GLB_HP2           = 1;
	localparam int GLB_HP1           = 2;
	localparam int GLB_LINK34        = 3;
	localparam int GLB_LINK12        = 4;
	localparam int GLB_FAST3         = 5;
	localparam int GLB_FAST1         = 6;
	localparam int GLB_LONG_POLY_SEL = 7;
	// ====================================================================
	// Reset values and timing
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam int          SYS_CLK_KHZ      = 1790;
	localparam int          BASE64_KHZ       = 64;
	localparam int          BASE15_KHZ       = 15;
	localparam int          DIV64_CYCLES     = SYS_CLK_KHZ / BASE64_KHZ;
	localparam int          DIV15_CYCLES     = SYS_CLK_KHZ / BASE15_KHZ;
	localparam logic [16:0] POLY17_SEED      = 17'h1_FFFF;
	localparam logic [8:0]  POLY9_SEED       = 9'h1FF;
	localparam logic [4:0]  POLY5_SEED       = 5'h1F;
	localparam logic [3:0]  POLY4_SEED       = 4'hF;
endpackage

// >>> rtl/fcag_top.sv
// Four-channel programmable sound generator with register port
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four channels, each with write-only 8-bit frequency register setting divider period.
// - Control bits 3:0 hold volume; bit 4 outputs volume level directly.
// - Control bit 5 toggles output per clock pulse; clear samples noise.
// - Bit 6 clear samples long polynomial, 17 or 9 bit by global bit 7.
// - Bit 6 set samples the 4-bit polynomial generator.
// - Control bit 7 clear masks timer pulses with 5-bit polynomial output.
// - Control bit 7 set feeds timer pulses directly to output stage.
// - Global bit 0 picks slow base clock: 64KHz clear, 15KHz set.
// - Global bit 7 shortens long polynomial to 9 bits; advances every cycle.
module fcag_top
	import fcag_pkg::*;
#(
	parameter int DIV64 = DIV64_CYCLES,
	parameter int DIV15 = DIV15_CYCLES
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	output logic      [3:0]        ch_level_o [4],
	output logic      [5:0]        mix_o
);
	// ====================================================================
	// Register file
	logic [7:0] freq [4];
	logic [7:0] ctrl [4];
	logic [7:0] glob;
	logic [7:0] next_freq [4];
	logic [7:0] next_ctrl [4];
	logic [7:0] next_glob;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [15:0] idx;
	logic        aligned;
	logic [3:0]  ch_out;
	logic [3:0]  hp_ff;

	assign idx     = addr_i[ADDR_W-1:2];
	assign aligned = (addr_i[1:0] == 2'b00);

	// Write decode; registers hold one byte in the low lane
	always_comb begin
		next_glob = glob;
		for (int i = 0; i < 4; i++) begin
			next_freq[i] = freq[i];
			next_ctrl[i] = ctrl[i];
			if (wr_i && aligned && idx == REG_CH1_FREQ_IDX + 16'(2 * i))
				next_freq[i] = wdata_i[7:0];
			if (wr_i && aligned && idx == REG_CH1_CTRL_IDX + 16'(2 * i))
				next_ctrl[i] = wdata_i[7:0];
		end
		if (wr_i && aligned && idx == REG_GLOBAL_IDX)
			next_glob = wdata_i[7:0];
	end

	// Read: registers are write-only; status word shows output flip-flops
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_i && aligned && idx == REG_STATUS_IDX)
			next_rdata = {24'h00_0000, hp_ff, ch_out};
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				freq[i] <= REG_RESET;
				ctrl[i] <= REG_RESET;
			end
			glob  <= REG_RESET;
			rdata <= 32'h0000_0000;
		end else begin
			freq  <= next_freq;
			ctrl  <= next_ctrl;
			glob  <= next_glob;
			rdata <= next_rdata;
		end
	end
	assign rdata_o = rdata;

	// ====================================================================
	// Polynomial generators and base clocks
	logic [16:0] p17, next_p17;
	logic [4:0]  p5, next_p5;
	logic [3:0]  p4, next_p4;
	logic [7:0]  c64, next_c64;
	logic [7:0]  c15, next_c15;
	logic        long_bit;
	logic        slow_tick;

	always_comb begin
		next_p5 = {p5[3:0], p5[4] ^ p5[2]};
		next_p4 = {p4[2:0], p4[3] ^ p4[2]};
		if (glob[GLB_LONG_POLY_SEL])
			next_p17 = {8'h00, p17[7:0], p17[8] ^ p17[4]};
		else
			next_p17 = {p17[15:0], p17[16] ^ p17[11]};
		if (next_p17 == 17'h0_0000)
			next_p17 = glob[GLB_LONG_POLY_SEL] ? {8'h00, POLY9_SEED} : POLY17_SEED;
		next_c64 = (c64 == 8'(DIV64 - 1)) ? 8'h00 : c64 + 8'h01;
		next_c15 = (c15 == 8'(DIV15 - 1)) ? 8'h00 : c15 + 8'h01;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			p17 <= POLY17_SEED;
			p5  <= POLY5_SEED;
			p4  <= POLY4_SEED;
			c64 <= 8'h00;
			c15 <= 8'h00;
		end else begin
			p17 <= next_p17;
			p5  <= next_p5;
			p4  <= next_p4;
			c64 <= next_c64;
			c15 <= next_c15;
		end
	end

	// Long poly tap follows the active length
	assign long_bit  = glob[GLB_LONG_POLY_SEL] ? p17[8] : p17[16];
	assign slow_tick = glob[GLB_SLOW_BASE_SEL] ? (c15 == 8'h00) : (c64 == 8'h00);

	// ====================================================================
	// Channel dividers; linked pairs count 16 bits on the odd channel's borrow
	logic [7:0] cnt [4];
	logic [7:0] next_cnt [4];
	logic [3:0] tick;
	logic [3:0] timer_pulse;
	logic [3:0] next_ch_out;
	logic [3:0] next_hp_ff;
	logic       link [4];

	assign link[0] = 1'b0;
	assign link[1] = glob[GLB_LINK12];
	assign link[2] = 1'b0;
	assign link[3] = glob[GLB_LINK34];

	// Clock source per channel: fast, slow, or previous channel's underflow
	always_comb begin
		tick[0] = glob[GLB_FAST1] ? 1'b1 : slow_tick;
		tick[1] = link[1] ? timer_pulse[0] : slow_tick;
		tick[2] = glob[GLB_FAST3] ? 1'b1 : slow_tick;
		tick[3] = link[3] ? timer_pulse[2] : slow_tick;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			logic zero;
			assign zero = (cnt[g] == 8'h00);
			// Low half of a linked pair still pulses to clock the high half; only its output flip-flop holds
			assign timer_pulse[g] = tick[g] && zero;
			always_comb begin
				next_cnt[g] = cnt[g];
				if (timer_pulse[g])
					next_cnt[g] = freq[g];
				else if (tick[g])
					next_cnt[g] = cnt[g] - 8'h01;
			end
			// Output flip-flop: tone toggles, noise samples the chosen source
			always_comb begin
				logic gated;
				logic src;
				gated = 1'b0;
				src   = 1'b0;
				gated = ctrl[g][CTRL_CLOCK_DIRECT] ? timer_pulse[g]
					: (timer_pulse[g] && p5[4]);
				src = ctrl[g][CTRL_NOISE_SELECT] ? p4[3] : long_bit;
				next_ch_out[g] = ch_out[g];
				if (gated && !((g == 0 && link[1]) || (g == 2 && link[3]))) begin
					if (ctrl[g][CTRL_PURE_TONE])
						next_ch_out[g] = ~ch_out[g];
					else
						next_ch_out[g] = src;
				end
			end
		end
	endgenerate

	// High-pass: channel 1/2 output latched on channel 3/4 pulse
	always_comb begin
		next_hp_ff = hp_ff;
		if (timer_pulse[2])
			next_hp_ff[0] = ch_out[0];
		if (timer_pulse[3])
			next_hp_ff[1] = ch_out[1];
		next_hp_ff[3:2] = 2'b00;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++)
				cnt[i] <= 8'h00;
			ch_out <= 4'h0;
			hp_ff  <= 4'h0;
		end else begin
			cnt    <= next_cnt;
			ch_out <= next_ch_out;
			hp_ff  <= next_hp_ff;
		end
	end

	// ====================================================================
	// Output levels and mix
	logic [3:0] level [4];
	logic [3:0] next_level [4];
	logic [5:0] mix, next_mix;
	logic [3:0] wave;

	always_comb begin
		wave[0] = glob[GLB_HP1] ? (ch_out[0] ^ hp_ff[0]) : ch_out[0];
		wave[1] = glob[GLB_HP2] ? (ch_out[1] ^ hp_ff[1]) : ch_out[1];
		wave[2] = ch_out[2];
		wave[3] = ch_out[3];
		next_mix = 6'h00;
		for (int i = 0; i < 4; i++) begin
			if (ctrl[i][CTRL_VOL_ONLY])
				next_level[i] = ctrl[i][CTRL_VOL_MSB:0];
			else
				next_level[i] = wave[i] ? ctrl[i][CTRL_VOL_MSB:0] : 4'h0;
			next_mix = next_mix + {2'b00, next_level[i]};
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++)
				level[i] <= 4'h0;
			mix <= 6'h00;
		end else begin
			level <= next_level;
			mix   <= next_mix;
		end
	end

	assign ch_level_o = level;
	assign mix_o      = mix;
endmodule
`default_nettype wire

// >>> bench/fcag_checker.sv
// Checker: port assertions of the sound generator
`timescale 1ns/1ps
`default_nettype none
module fcag_checker
	import fcag_pkg::*;
(
	input wire logic              clk_sys_i,
	input wire logic              rst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0]       wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [31:0]       rdata_o,
	input wire logic [3:0]        ch_level_o [4],
	input wire logic [5:0]        mix_o
);
	// ========
	// Decoded control writes and status reads
	logic w1;
	logic w4;
	logic rs;
	assign w1 = wr_i && addr_i == {REG_CH1_CTRL_IDX, 2'b00};
	assign w4 = wr_i && addr_i == {REG_CH4_CTRL_IDX, 2'b00};
	assign rs = rd_i && addr_i == {REG_STATUS_IDX, 2'b00};
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// ========
	// Assertions
	property p_rd_only; !rd_i |=> rdata_o == 32'h0; endproperty
	a_rd_only: assert property (p_rd_only) else $error("stray read data");
	property p_wo; rd_i && !rs |=> rdata_o == 32'h0; endproperty
	a_wo: assert property (p_wo) else $error("register read back");
	property p_stat; rs |=> rdata_o[31:6] == 26'h0; endproperty
	a_stat: assert property (p_stat) else $error("status upper bits set");
	property p_mix; mix_o == 6'(ch_level_o[0]) + 6'(ch_level_o[1])
		+ 6'(ch_level_o[2]) + 6'(ch_level_o[3]); endproperty
	a_mix: assert property (p_mix) else $error("mix is not the level sum");
	property p_v1; w1 && wdata_i[CTRL_VOL_ONLY] ##1 !w1
		|=> ch_level_o[0] == $past(wdata_i[3:0], 2); endproperty
	a_v1: assert property (p_v1) else $error("channel 1 volume level wrong");
	property p_v4; w4 && wdata_i[CTRL_VOL_ONLY] ##1 !w4
		|=> ch_level_o[3] == $past(wdata_i[3:0], 2); endproperty
	a_v4: assert property (p_v4) else $error("channel 4 volume level wrong");
	property p_hold; w1 && wdata_i[7:4] == 4'h1 ##1 !w1 [*4] |=> $stable(ch_level_o[0]); endproperty
	a_hold: assert property (p_hold) else $error("volume level moved");
	property p_rst; $fell(rst_i) |-> mix_o == 6'h0 && rdata_o == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	// Main scenarios reached
	c_vol: cover property (w1 && wdata_i[CTRL_VOL_ONLY]);
	c_stat: cover property (rs);
	c_tone: cover property ($changed(ch_level_o[0]));
endmodule
bind fcag_top fcag_checker i_fcag_checker (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .ch_level_o, .mix_o);
`default_nettype wire

// >>> bench/fcag_top_tb_top.sv
// Testbench: register port and sound level checks
`timescale 1ns/1ps
`default_nettype none
module fcag_top_tb_top
	import fcag_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [17:0] addr_i = 18'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] d;
	logic [3:0]  ch_level_o [4];
	logic [3:0]  s [600];
	logic [5:0]  mix_o;
	int          n_errors = 0;
	int          tests_run = 0;
	int          tr;
	// Rows: channel, control byte, expected level
	logic [15:0] rows [6] = '{16'h01FF, 16'h0100, 16'h1955, 16'h23AA, 16'h3D77, 16'h3100};
	// Clock, 200 MHz
	always #2.5 clk_sys_i = ~clk_sys_i;
	fcag_top #(.DIV64(4), .DIV15(8)) i_fcag_top (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .ch_level_o, .mix_o);
	// ========
	// Helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] v, input logic [1:0] lo = 2'b00);
		@(posedge clk_sys_i);
		addr_i <= {i, lo};
		wdata_i <= {24'h0, v};
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
	endtask
	task automatic rd(input logic [15:0] i);
		@(posedge clk_sys_i);
		addr_i <= {i, 2'b00};
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		d = rdata_o;
	endtask
	task automatic meas(input int ch, input int n);
		repeat (20) @(posedge clk_sys_i);
		tr = 0;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_i);
			s[i] = ch_level_o[ch];
			if (i > 0 && s[i] !== s[i - 1]) tr++;
		end
	endtask
	function automatic logic per(input int p);
		per = 1'b1;
		for (int i = 0; i + p < 600; i++) if (s[i] !== s[i + p]) per = 1'b0;
	endfunction
	task automatic test_done();
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog, run needs some 2500 cycles
	initial begin
		#40us;
		chk("watchdog", 32'h1, 32'h0);
		test_done();
	end
	// Main sequence: reset, table rows, then awkward cases
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("mix", 32'(mix_o), 32'h0);
		foreach (rows[k]) begin
			wr(REG_CH1_CTRL_IDX + 16'(2 * rows[k][13:12]), rows[k][11:4]);
			chk("level", 32'(ch_level_o[rows[k][13:12]]), 32'(rows[k][3:0]));
		end
		chk("mix", 32'(mix_o), 32'hF);
		rd(REG_CH1_FREQ_IDX);
		chk("write-only", d, 32'h0);
		wr(REG_CH1_CTRL_IDX, 8'h1F, 2'b01);
		chk("unaligned", 32'(ch_level_o[0]), 32'h0);
		rd(REG_STATUS_IDX);
		chk("status", 32'(d[31:6]), 32'h0);
		// Direct tone on the fast clock, divider period f+1
		wr(REG_GLOBAL_IDX, 8'h40);
		wr(REG_CH1_CTRL_IDX, 8'hA8);
		for (int f = 1; f < 8; f = 2 * f + 1) begin
			wr(REG_CH1_FREQ_IDX, 8'(f));
			meas(0, 41);
			chk("tone", tr, 40 / (f + 1));
		end
		// Slow base clock choice
		wr(REG_CH2_FREQ_IDX, 8'h00);
		wr(REG_CH2_CTRL_IDX, 8'hA4);
		for (int g = 0; g < 2; g++) begin
			wr(REG_GLOBAL_IDX, 8'(g));
			meas(1, 41);
			chk("slow", tr, 10 / (g + 1));
		end
		// Masked clock and noise sources
		wr(REG_GLOBAL_IDX, 8'h40);
		wr(REG_CH1_FREQ_IDX, 8'h00);
		wr(REG_CH1_CTRL_IDX, 8'h28);
		meas(0, 41);
		chk("masked", 32'(tr > 0 && tr < 40), 32'h1);
		wr(REG_CH1_CTRL_IDX, 8'hC8);
		meas(0, 600);
		chk("poly4", 32'(per(15) && tr > 0), 32'h1);
		wr(REG_GLOBAL_IDX, 8'hC0);
		wr(REG_CH1_CTRL_IDX, 8'h88);
		meas(0, 600);
		chk("poly9", 32'({per(511), per(15)}), 32'h2);
		wr(REG_GLOBAL_IDX, 8'h40);
		meas(0, 600);
		chk("poly17", 32'(per(511)), 32'h0);
		// Linked pair: channel 2 counts channel 1 underflows, channel 1 output frozen
		wr(REG_GLOBAL_IDX, 8'h50);
		wr(REG_CH1_FREQ_IDX, 8'h01);
		wr(REG_CH1_CTRL_IDX, 8'hA8);
		wr(REG_CH2_FREQ_IDX, 8'h01);
		wr(REG_CH2_CTRL_IDX, 8'hA8);
		meas(1, 41);
		chk("linked", tr, 32'd10);
		meas(0, 41);
		chk("link low", tr, 32'd0);
		// High-pass: channel 1 latched every cycle by fast channel 3
		wr(REG_CH3_FREQ_IDX, 8'h00);
		wr(REG_GLOBAL_IDX, 8'h64);
		meas(0, 41);
		chk("highpass", tr, 32'd40);
		test_done();
	end
endmodule
`default_nettype wire
